//--- rtl/lazy_context_task_switch.sv
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "ltsw_defs.svh"

module lazy_context_task_switch
    import ltsw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // decode stage
    input  decodeReq_t       decReq,
    output logic             issueOk,
    output logic             unitNotAvailableTrap,
    // switch triggers and pipeline
    input  switchReq_t       swReq,
    input  wire logic        pipeIdle,
    output logic             switchBusy,
    output logic             swRefused,
    output logic             faultPulse,
    output fault_t           faultKind,
    output logic             fetchStart,
    output logic      [31:0] fetchBase,
    // task-state memory
    output memReq_t          memReq,
    input  wire logic        memAck,
    // tag rebuild
    input  fprImage_t        tagIn,
    output logic      [1:0]  fullTag,
    output logic             fullTagValid
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    swState_t    state_q;
    logic        taskSwitchedFlag_q;
    logic        legacyMode_q;
    logic [31:0] curBase_q;
    logic [31:0] linkBase_q;
    logic [31:0] targetBase_q;
    logic [31:0] trapCount_q;
    logic        moverStart;
    logic        moverLoad;
    logic [31:0] moverBase;
    logic        moverDone;
    logic        switchDone;
    logic        ctrlWrite;
    logic        fpAttempt;
    logic        trigger;
    logic        limitShort;
    logic        busyHit;
    logic        accept;
    logic [1:0]  tagComb;

    function automatic logic hitAddr(input logic [7:0] a, input logic [7:0] r);
        hitAddr = (a == r);
    endfunction : hitAddr

    ////////////////////////////////////////////////////////////////////////
    // decode gating

    assign fpAttempt = decReq.valid && decReq.isFpMedia;

    // flag is looked at in the decode cycle, so a write lands on the next one
    always_comb begin
        unitNotAvailableTrap = fpAttempt && taskSwitchedFlag_q;
        // nothing issues while trapping, so only trapCount_q changes
        issueOk = decReq.valid && !unitNotAvailableTrap
                  && (state_q == SW_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            trapCount_q <= '0;
        end else if (unitNotAvailableTrap) begin
            trapCount_q <= trapCount_q + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    assign ctrlWrite  = regWr && hitAddr(regAddr, `ADDR_CTRL);
    assign switchDone = (state_q == SW_LOAD) && moverDone;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            taskSwitchedFlag_q <= 1'(`CTRL_RESET >> `CTRL_TS_BIT);
        end else if (switchDone) begin
            // hardware set beats a software clear in the same cycle
            taskSwitchedFlag_q <= 1'b1;
        end else if (ctrlWrite) begin
            taskSwitchedFlag_q <= regWrData[`CTRL_TS_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            legacyMode_q <= 1'(`CTRL_RESET >> `CTRL_LEGACY_BIT);
        end else if (ctrlWrite && state_q == SW_IDLE) begin
            // mode frozen mid-switch so a switch always finishes cleanly
            legacyMode_q <= regWrData[`CTRL_LEGACY_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger checks

    assign trigger    = swReq.valid && (state_q == SW_IDLE);
    assign limitShort = swReq.areaLimit < `MIN_AREA_LIMIT;
    // the linked task is busy by design, so the return skips that check
    assign busyHit    = swReq.targetBusy && (swReq.kind != KIND_INTERRUPT_RETURN);
    assign accept     = trigger && legacyMode_q && !limitShort && !busyHit;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            swRefused  <= 1'b0;
            faultPulse <= 1'b0;
            faultKind  <= FAULT_NONE;
        end else begin
            swRefused  <= trigger && !legacyMode_q;
            faultPulse <= trigger && legacyMode_q && (limitShort || busyHit);
            if (trigger && legacyMode_q && limitShort) begin
                faultKind <= FAULT_TASK_STATE;
            end else if (trigger && legacyMode_q && busyHit) begin
                faultKind <= FAULT_PROT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switch sequence

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= SW_IDLE;
        end else begin
            unique case (state_q)
                SW_IDLE: begin
                    if (accept) begin
                        state_q <= SW_DRAIN;
                    end
                end
                SW_DRAIN: begin
                    if (pipeIdle) begin
                        state_q <= SW_SAVE;
                    end
                end
                SW_SAVE: begin
                    if (moverDone) begin
                        state_q <= SW_LOAD;
                    end
                end
                SW_LOAD: begin
                    if (moverDone) begin
                        state_q <= SW_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            targetBase_q <= `BASE_RESET;
        end else if (accept) begin
            targetBase_q <= (swReq.kind == KIND_INTERRUPT_RETURN) ? linkBase_q
                                                      : swReq.areaBase;
        end
    end

    // nesting kinds remember the caller; a plain jump does not nest
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            linkBase_q <= `BASE_RESET;
        end else if (accept && (swReq.kind == KIND_CALL || swReq.kind == KIND_EVENT)) begin
            linkBase_q <= curBase_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            curBase_q  <= `BASE_RESET;
            fetchStart <= 1'b0;
            fetchBase  <= `BASE_RESET;
        end else begin
            fetchStart <= switchDone;
            if (switchDone) begin
                curBase_q <= targetBase_q;
                fetchBase <= targetBase_q;
            end
        end
    end

    // save the old task first, then load the new one
    always_comb begin
        moverStart = ((state_q == SW_DRAIN) && pipeIdle)
                     || ((state_q == SW_SAVE) && moverDone);
        moverLoad  = (state_q == SW_SAVE);
        moverBase  = (state_q == SW_SAVE) ? targetBase_q : curBase_q;
    end

    assign switchBusy = (state_q != SW_IDLE);

    task_state_mover mover (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (moverStart),
        .loadDir (moverLoad),
        .base    (moverBase),
        .done    (moverDone),
        .memReq  (memReq),
        .memAck  (memAck)
    );

    ////////////////////////////////////////////////////////////////////////
    // tag rebuild

    fpr_tag_classifier classifier (
        .exponent    (tagIn.exponent),
        .significand (tagIn.significand),
        .oneBitTag   (tagIn.oneBitTag),
        .fullTag     (tagComb)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fullTag      <= `TAG_EMPTY;
            fullTagValid <= 1'b0;
        end else begin
            fullTagValid <= tagIn.valid;
            if (tagIn.valid) begin
                fullTag <= tagComb;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= '0;
            if (hitAddr(regAddr, `ADDR_CTRL)) begin
                regRdData[`CTRL_TS_BIT]     <= taskSwitchedFlag_q;
                regRdData[`CTRL_LEGACY_BIT] <= legacyMode_q;
            end else if (hitAddr(regAddr, `ADDR_STATUS)) begin
                regRdData[`STAT_BUSY_BIT]              <= switchBusy;
                regRdData[`STAT_FAULT_LO +: 2]         <= faultKind;
                regRdData[`STAT_TS_BIT]                <= taskSwitchedFlag_q;
            end else if (hitAddr(regAddr, `ADDR_TRAP_COUNT)) begin
                regRdData <= trapCount_q;
            end else if (hitAddr(regAddr, `ADDR_CUR_BASE)) begin
                regRdData <= curBase_q;
            end else if (hitAddr(regAddr, `ADDR_LINK_BASE)) begin
                regRdData <= linkBase_q;
            end
        end else begin
            regRdData <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_trapWhenSet;
        @(posedge sys_clk) disable iff (rst)
        fpAttempt && taskSwitchedFlag_q |-> unitNotAvailableTrap && !issueOk;
    endproperty
    a_trapWhenSet: assert property (p_trapWhenSet)
        else $error("media use with flag set did not trap");

    property p_runWhenClear;
        @(posedge sys_clk) disable iff (rst)
        fpAttempt && !taskSwitchedFlag_q && state_q == SW_IDLE
            |-> issueOk && !unitNotAvailableTrap;
    endproperty
    a_runWhenClear: assert property (p_runWhenClear)
        else $error("media use with flag clear was blocked");

    property p_preciseTrap;
        @(posedge sys_clk) disable iff (rst)
        unitNotAvailableTrap |-> !issueOk ##1 trapCount_q == $past(trapCount_q) + 32'h1;
    endproperty
    a_preciseTrap: assert property (p_preciseTrap)
        else $error("trapping instruction issued or trap not counted");

    property p_setOnSwitch;
        @(posedge sys_clk) disable iff (rst)
        switchDone |=> taskSwitchedFlag_q && fetchStart;
    endproperty
    a_setOnSwitch: assert property (p_setOnSwitch)
        else $error("switch did not set the flag");

    property p_longModeRefuse;
        @(posedge sys_clk) disable iff (rst)
        trigger && !legacyMode_q |=> swRefused && state_q == SW_IDLE
            && (taskSwitchedFlag_q == $past(taskSwitchedFlag_q) || $past(ctrlWrite));
    endproperty
    a_longModeRefuse: assert property (p_longModeRefuse)
        else $error("long mode trigger was not refused");

    sequence s_saveDone;
        state_q == SW_SAVE && moverDone;
    endsequence

    // load item 0 shows with the state change; a fast ack may move it on after
    sequence s_loadBegins;
        ##1 state_q == SW_LOAD && memReq.valid && !memReq.write
            && memReq.item == ITEM_CODE;
    endsequence

    property p_saveThenLoad;
        @(posedge sys_clk) disable iff (rst)
        s_saveDone |-> s_loadBegins;
    endproperty
    a_saveThenLoad: assert property (p_saveThenLoad)
        else $error("load did not follow the save");

    property p_drainFirst;
        @(posedge sys_clk) disable iff (rst)
        state_q == SW_DRAIN && !pipeIdle |=> state_q == SW_DRAIN && !memReq.valid;
    endproperty
    a_drainFirst: assert property (p_drainFirst)
        else $error("save began before the pipeline drained");

    property p_shortLimit;
        @(posedge sys_clk) disable iff (rst)
        trigger && legacyMode_q && limitShort
            |=> faultPulse && faultKind == FAULT_TASK_STATE ##1 state_q == SW_IDLE;
    endproperty
    a_shortLimit: assert property (p_shortLimit)
        else $error("short area limit not faulted");

    property p_busyTarget;
        @(posedge sys_clk) disable iff (rst)
        trigger && legacyMode_q && !limitShort && busyHit
            |=> faultPulse && faultKind == FAULT_PROT && state_q == SW_IDLE;
    endproperty
    a_busyTarget: assert property (p_busyTarget)
        else $error("busy target not faulted");

    property p_returnToLink;
        @(posedge sys_clk) disable iff (rst)
        accept && swReq.kind == KIND_INTERRUPT_RETURN |=> targetBase_q == $past(linkBase_q);
    endproperty
    a_returnToLink: assert property (p_returnToLink)
        else $error("return did not target the linked task");

    property p_emptyTag;
        @(posedge sys_clk) disable iff (rst)
        tagIn.valid && !tagIn.oneBitTag |=> fullTagValid && fullTag == `TAG_EMPTY;
    endproperty
    a_emptyTag: assert property (p_emptyTag)
        else $error("empty register not tagged empty");

endmodule : lazy_context_task_switch

//--- rtl/ltsw_defs.svh
`ifndef LTSW_DEFS_SVH
`define LTSW_DEFS_SVH

// register port map
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_TRAP_COUNT  8'h08
`define ADDR_CUR_BASE    8'h0C
`define ADDR_LINK_BASE   8'h10

// control fields
`define CTRL_TS_BIT      0
`define CTRL_LEGACY_BIT  1
`define CTRL_RESET       2'h2

// status fields
`define STAT_BUSY_BIT    0
`define STAT_FAULT_LO    1
`define STAT_TS_BIT      3

// task-state area
`define MIN_AREA_LIMIT   32'h0000_0067
`define BASE_RESET       32'h0000_0000

// full tag codes
`define TAG_VALID        2'h0
`define TAG_ZERO         2'h1
`define TAG_SPECIAL      2'h2
`define TAG_EMPTY        2'h3

// extended-precision layout
`define EXP_ALL_ONES     15'h7FFF
`define EXP_ALL_ZEROS    15'h0000
`define SIG_INT_BIT      63
`define SIG_FRAC_HI      62

`endif

//--- rtl/ltsw_pkg.sv
package ltsw_pkg;

    typedef enum {SW_IDLE, SW_DRAIN, SW_SAVE, SW_LOAD} swState_t;

    typedef enum logic [1:0] {KIND_CALL, KIND_JUMP, KIND_EVENT, KIND_INTERRUPT_RETURN} swKind_t;

    typedef enum logic [1:0] {FAULT_NONE, FAULT_TASK_STATE, FAULT_PROT} fault_t;

    // one step per piece of per-task state, walked in this order
    typedef enum logic [3:0] {
        ITEM_CODE, ITEM_DATA_SEG, ITEM_STACK_SEG, ITEM_GPR, ITEM_FLAGS,
        ITEM_LDT, ITEM_TASK_LINK, ITEM_BITMAPS, ITEM_PAGE_BASE
    } taskItem_t;

    typedef struct packed {
        logic       valid;
        logic       isFpMedia;
    } decodeReq_t;

    typedef struct packed {
        logic        valid;
        swKind_t     kind;
        logic [31:0] areaBase;
        logic [31:0] areaLimit;
        logic        targetBusy;
    } switchReq_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] base;
        taskItem_t   item;
    } memReq_t;

    typedef struct packed {
        logic        valid;
        logic        oneBitTag;
        logic [14:0] exponent;
        logic [63:0] significand;
    } fprImage_t;

endpackage : ltsw_pkg

//--- rtl/fpr_tag_classifier.sv
`timescale 1ns/10ps
`include "ltsw_defs.svh"

module fpr_tag_classifier
    import ltsw_pkg::*;
(
    // saved register image
    input  wire logic [14:0] exponent,
    input  wire logic [63:0] significand,
    input  wire logic        oneBitTag,
    // rebuilt tag
    output logic      [1:0]  fullTag
);

    logic intBit;
    logic fracZero;

    assign intBit   = significand[`SIG_INT_BIT];
    assign fracZero = (significand[`SIG_FRAC_HI:0] == '0);

    always_comb begin
        if (!oneBitTag) begin
            fullTag = `TAG_EMPTY;
        end else if (exponent == `EXP_ALL_ZEROS) begin
            fullTag = (!intBit && fracZero) ? `TAG_ZERO : `TAG_SPECIAL;
        end else if (exponent == `EXP_ALL_ONES) begin
            fullTag = `TAG_SPECIAL;
        end else begin
            // unnormals have no integer bit and count as special
            fullTag = intBit ? `TAG_VALID : `TAG_SPECIAL;
        end
    end

endmodule : fpr_tag_classifier

//--- rtl/task_state_mover.sv
`timescale 1ns/10ps
`include "ltsw_defs.svh"

module task_state_mover
    import ltsw_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // command
    input  wire logic        start,
    input  wire logic        loadDir,
    input  wire logic [31:0] base,
    output logic             done,
    // memory side
    output memReq_t          memReq,
    input  wire logic        memAck
);

    logic active_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_q <= 1'b0;
            memReq   <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !active_q) begin
                active_q       <= 1'b1;
                memReq.valid   <= 1'b1;
                memReq.write   <= !loadDir;
                memReq.base    <= base;
                memReq.item    <= ITEM_CODE;
            end else if (active_q && memAck) begin
                if (memReq.item == ITEM_PAGE_BASE) begin
                    active_q     <= 1'b0;
                    memReq.valid <= 1'b0;
                    done         <= 1'b1;
                end else begin
                    // every piece of task state, one beat each
                    memReq.item <= taskItem_t'(memReq.item + 4'h1);
                end
            end
        end
    end

endmodule : task_state_mover

//--- testbench/lazy_context_task_switch_tb.sv
`timescale 1ns/10ps
`include "ltsw_defs.svh"

module lazy_context_task_switch_tb
    import ltsw_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdData;
    decodeReq_t  decReq = '0;
    logic        issueOk;
    logic        unitNotAvailableTrap;
    switchReq_t  swReq = '0;
    logic        pipeIdle = 1'b0;
    logic        switchBusy;
    logic        swRefused;
    logic        faultPulse;
    fault_t      faultKind;
    logic        fetchStart;
    logic [31:0] fetchBase;
    memReq_t     memReq;
    logic        memAck = 1'b0;
    fprImage_t   tagIn = '0;
    logic [1:0]  fullTag;
    logic        fullTagValid;
    int          err_count = 0;
    int          total_checks = 0;
    logic [31:0] curBase = 32'h0;
    logic [31:0] linkBase = 32'h0;
    logic [31:0] trapCnt = 32'h0;

    always #10 sys_clk = ~sys_clk;

    lazy_context_task_switch i_dut (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .decReq(decReq),
        .issueOk(issueOk), .unitNotAvailableTrap(unitNotAvailableTrap), .swReq(swReq),
        .pipeIdle(pipeIdle), .switchBusy(switchBusy), .swRefused(swRefused),
        .faultPulse(faultPulse), .faultKind(faultKind), .fetchStart(fetchStart),
        .fetchBase(fetchBase), .memReq(memReq), .memAck(memAck), .tagIn(tagIn),
        .fullTag(fullTag), .fullTagValid(fullTagValid)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chkVal(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got 0x%0h exp 0x%0h", $time, got, exp);
        end
    endtask : chkVal

    task automatic chkTag(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got 0x%0h exp 0x%0h", $time, got, exp);
        end
    endtask : chkTag

    function automatic logic [1:0] expTag(input logic t, input logic [14:0] e,
                                          input logic [63:0] s);
        if (!t) return 2'h3;
        if (e == 15'h0000) return (s == 64'h0) ? 2'h1 : 2'h2;
        if (e == 15'h7FFF) return 2'h2;
        return s[63] ? 2'h0 : 2'h2;
    endfunction : expTag

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) begin regAddr <= a; regWrData <= d; regWr <= 1'b1; end
        @(posedge sys_clk) regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk) begin regAddr <= a; regRd <= 1'b1; end
        @(posedge sys_clk) regRd <= 1'b0;
        #1 chkVal(64'(regRdData), 64'(e));
    endtask : rd

    // bounded wait; a hang is reported and ends the run
    task automatic waitFor(input int sel);
        int n;
        n = 0;
        while (!((sel == 0) ? (memReq.valid === 1'b1) : (fetchStart === 1'b1))) begin
            @(posedge sys_clk);
            #1 n++;
            if (n > 60) begin
                err_count++;
                $display("MISMATCH at %0t: wait got 0x0 exp 0x1", $time);
                finish_test();
            end
        end
    endtask : waitFor

    task automatic trigger(input swKind_t k, input logic [31:0] b, input logic [31:0] lim,
                           input logic busy);
        @(posedge sys_clk) swReq <= '{1'b1, k, b, lim, busy};
        @(posedge sys_clk) swReq.valid <= 1'b0;
        #1;
    endtask : trigger

    ////////////////////////////////////////////////////////////////////////////////
    task automatic runSwitch(input swKind_t k, input logic [31:0] b);
        logic [31:0] tgt;
        logic [31:0] oldBase;
        oldBase = curBase;
        tgt = (k == KIND_INTERRUPT_RETURN) ? linkBase : b;
        wr(`ADDR_CTRL, 32'h2);
        trigger(k, b, 32'h67, k == KIND_INTERRUPT_RETURN);
        chkVal(64'(switchBusy), 64'h1);
        // pipeline still busy: nothing may be saved yet
        repeat (3) begin
            @(posedge sys_clk);
            #1 chkVal(64'(memReq.valid), 64'h0);
        end
        @(posedge sys_clk) pipeIdle <= 1'b1;
        #1;
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 9; i++) begin
                waitFor(0);
                chkVal(64'({memReq.write, memReq.base, 4'(memReq.item)}),
                       64'({p == 0, (p == 0) ? oldBase : tgt, 4'(i)}));
                // slow memory now and then
                repeat ($urandom_range(0, 2)) @(posedge sys_clk);
                @(posedge sys_clk) memAck <= 1'b1;
                @(posedge sys_clk) memAck <= 1'b0;
                #1;
            end
        end
        waitFor(1);
        chkVal(64'(fetchBase), 64'(tgt));
        @(posedge sys_clk) pipeIdle <= 1'b0;
        rd(`ADDR_CTRL, 32'h3);
        if (k == KIND_CALL || k == KIND_EVENT) linkBase = oldBase;
        curBase = tgt;
        rd(`ADDR_CUR_BASE, curBase);
        rd(`ADDR_LINK_BASE, linkBase);
    endtask : runSwitch

    task automatic faultCase(input logic [31:0] lim, input logic busy, input logic [1:0] kd);
        trigger(KIND_JUMP, 32'h0000_5000, lim, busy);
        chkVal({62'h0, faultPulse, switchBusy}, {62'h0, 1'b1, 1'b0});
        rd(`ADDR_STATUS, {28'h0, 1'b1, kd, 1'b0});
    endtask : faultCase

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [63:0] s;
        logic [14:0] e;
        logic        t;
        void'($urandom(32'h2B12041F));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #1 chkTag(fullTag, 2'h3);
        rd(`ADDR_CTRL, 32'h2);
        rd(8'h20, 32'h0);
        $display("test reset done");

        for (int i = 0; i < 60; i++) begin
            s = {$urandom, $urandom};
            t = (i % 7) != 0;
            case (i % 4)
                0: e = 15'h0000;
                1: e = 15'h7FFF;
                default: e = 15'(1 + $urandom_range(0, 32765));
            endcase
            if (i % 3 == 0) s[62:0] = 63'h0;
            if (i % 5 == 0) s[63] = 1'b0;
            @(posedge sys_clk) tagIn <= '{1'b1, t, e, s};
            @(posedge sys_clk) tagIn.valid <= 1'b0;
            #1 chkTag(fullTag, expTag(t, e, s));
            chkVal(64'(fullTagValid), 64'h1);
        end
        $display("test tag done");

        wr(`ADDR_CTRL, 32'h3);
        @(posedge sys_clk) decReq <= '{1'b1, 1'b1};
        #1 chkVal(64'({unitNotAvailableTrap, issueOk}), 64'h2);
        trapCnt++;
        @(posedge sys_clk) decReq <= '{1'b1, 1'b0};
        #1 chkVal(64'({unitNotAvailableTrap, issueOk}), 64'h1);
        @(posedge sys_clk) decReq <= '0;
        rd(`ADDR_TRAP_COUNT, trapCnt);
        wr(`ADDR_CTRL, 32'h2);
        @(posedge sys_clk) decReq <= '{1'b1, 1'b1};
        #1 chkVal(64'({unitNotAvailableTrap, issueOk}), 64'h1);
        @(posedge sys_clk) decReq <= '0;
        $display("test trap done");

        runSwitch(KIND_CALL, 32'h0000_1000);
        runSwitch(KIND_JUMP, 32'h0000_2000);
        runSwitch(KIND_EVENT, 32'h0000_3000);
        runSwitch(KIND_INTERRUPT_RETURN, 32'h0000_4000);
        $display("test switch done");

        faultCase(32'h66, 1'b0, 2'h1);
        faultCase(32'h66, 1'b1, 2'h1);
        faultCase(32'h67, 1'b1, 2'h2);
        $display("test fault done");

        wr(`ADDR_CTRL, 32'h0);
        trigger(KIND_CALL, 32'h0000_6000, 32'h67, 1'b0);
        chkVal(64'({swRefused, switchBusy}), 64'h2);
        rd(`ADDR_CTRL, 32'h0);
        $display("test long mode done");
        finish_test();
    end
endmodule : lazy_context_task_switch_tb
